// >>> rtl/fpd_ctrl.sv
// Fast page DRAM controller: drives RAS, two byte strobes, WE, OE, address and data.
// Assumes the DRAM data inputs are synchronous to core_clk; no software registers.
module fpd_ctrl
  import fpd_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES = PWRUP_CYC,
  parameter int unsigned REF_CYCLES   = REF_INT_CYC
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire fpd_pkg::fpd_req_t    req,
  output logic                      rsp_valid,
  output logic [DATA_BITS-1:0]      rsp_rdata,
  output logic                      init_done,
  output fpd_pkg::fpd_pins_t        pins,
  input  wire logic [DATA_BITS-1:0] dq_in,
  output logic [DATA_BITS-1:0]      dq_out,
  output logic                      dq_oe
);
  import fpd_pkg::*;

  typedef enum logic [3:0] {
    S_PWRUP, S_INIT, S_IDLE, S_ROW, S_COL, S_ACCESS, S_WRPH, S_CAS_UP,
    S_PRE, S_SFR_STROBE, S_SFR_ROW
  } fpd_state_t;

  fpd_state_t            state;
  logic [CNT_BITS-1:0]   wait_cnt;
  logic [CNT_BITS-1:0]   ref_cnt;
  logic [3:0]            init_cnt;
  logic                  ref_due;
  logic                  page_open;
  logic [ROW_BITS-1:0]   open_row;
  logic [CNT_BITS-1:0]   ras_age;
  fpd_req_t              cur;

  wire [ROW_BITS-1:0] req_row    = req.addr[ADDR_BITS-1:COL_BITS];
  wire [COL_BITS-1:0] req_col    = req.addr[COL_BITS-1:0];
  wire                wait_done  = (wait_cnt == '0);
  wire                page_hit   = page_open && (req_row == open_row);
  wire                ras_min_ok = (ras_age >= CNT_BITS'(RAS_CYC));
  wire                is_write   = (cur.op == FPD_OP_WRITE);
  // Open page (keep_page set) is held until a request misses it or has keep_page clear; refresh forces closure
  // Waiting on wait_done keeps the precharge after a cycle from being cut short
  wire                take       = (state == S_IDLE) && wait_done && req_valid && !ref_due &&
                                   (!page_open || page_hit);
  assign req_ready = take;

  // Free-running timer keeps the period fixed however late each refresh lands
  wire ref_tick = (ref_cnt >= CNT_BITS'(REF_CYCLES - 1));
  wire ref_done = (state == S_SFR_ROW) && wait_done;

  // A tick meeting a finishing refresh wins, so no interval goes unserved
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt <= '0;
      ref_due <= 1'b0;
    end else begin
      ref_cnt <= ref_tick ? '0 : ref_cnt + 1'b1;
      if (ref_tick) begin
        ref_due <= 1'b1;
      end else if (ref_done) begin
        ref_due <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ras_age <= '0;
    end else if (pins.ras_n) begin
      ras_age <= '0;
    end else if (!ras_min_ok) begin
      ras_age <= ras_age + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= S_PWRUP;
      wait_cnt  <= CNT_BITS'(PWRUP_CYCLES);
      init_cnt  <= '0;
      init_done <= 1'b0;
      page_open <= 1'b0;
      open_row  <= '0;
      cur       <= '0;
      pins      <= '{ras_n: 1'b1, lower_byte_strobe_n: 1'b1, upper_byte_strobe_n: 1'b1,
                     we_n: 1'b1, oe_n: 1'b1, addr: '0};
      dq_out    <= '0;
      dq_oe     <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (!wait_done) begin
        wait_cnt <= wait_cnt - 1'b1;
      end
      unique case (state)
        S_PWRUP: if (wait_done) begin
          state <= S_INIT;
        end
        S_INIT: if (wait_done) begin
          // Eight RAS-only cycles with strobes high, row from init counter
          if (init_cnt == 4'(INIT_CYCLES)) begin
            init_done <= 1'b1;
            state     <= S_IDLE;
          end else if (pins.ras_n) begin
            pins.addr  <= ROW_BITS'(init_cnt);
            pins.ras_n <= 1'b0;
            wait_cnt   <= CNT_BITS'(RAS_CYC - 1);
          end else begin
            pins.ras_n <= 1'b1;
            init_cnt   <= init_cnt + 1'b1;
            wait_cnt   <= CNT_BITS'(RP_CYC - 1);
          end
        end
        S_IDLE: if (wait_done) begin
          if (ref_due || (req_valid && page_open && !page_hit)) begin
            if (page_open) begin
              state <= S_PRE;
            end else if (ref_due) begin
              // Strobes fall first; address pins are don't-care
              pins.lower_byte_strobe_n <= 1'b0;
              pins.upper_byte_strobe_n <= 1'b0;
              wait_cnt <= CNT_BITS'(CP_CYC - 1);
              state    <= S_SFR_STROBE;
            end
          end else if (take) begin
            cur <= req;
            if (page_hit) begin
              pins.addr <= req_col;
              state     <= S_COL;
            end else begin
              pins.addr <= req_row;
              state     <= S_ROW;
            end
          end
        end
        S_ROW: begin
          pins.ras_n <= 1'b0;
          open_row   <= cur.addr[ADDR_BITS-1:COL_BITS];
          page_open  <= 1'b1;
          wait_cnt   <= CNT_BITS'(RAC_CYC - CAC_CYC);
          state      <= S_COL;
        end
        S_COL: if (wait_done) begin
          pins.addr <= cur.addr[COL_BITS-1:0];
          pins.we_n <= !is_write;
          pins.oe_n <= is_write;
          dq_out    <= cur.wdata;
          dq_oe     <= is_write;
          state     <= S_ACCESS;
        end
        S_ACCESS: begin
          // Column held one cycle before strobes fall; strobe only enabled bytes
          pins.lower_byte_strobe_n <= !cur.byte_en[0];
          pins.upper_byte_strobe_n <= !cur.byte_en[1];
          wait_cnt <= CNT_BITS'((AA_CYC > PC_CYC ? AA_CYC : PC_CYC) - 1);
          state    <= (cur.op == FPD_OP_RMW) ? S_WRPH : S_CAS_UP;
        end
        S_WRPH: if (wait_done) begin
          // Read phase is captured before OE rises, then the write phase follows
          rsp_rdata <= dq_in;
          rsp_valid <= 1'b1;
          pins.oe_n <= 1'b1;
          dq_oe     <= 1'b1;
          pins.we_n <= 1'b0;
          cur.op    <= FPD_OP_WRITE;
          wait_cnt  <= CNT_BITS'(CAC_CYC - 1);
        end else if (cur.op == FPD_OP_WRITE) begin
          state <= S_CAS_UP;
        end
        S_CAS_UP: if (wait_done) begin
          if (cur.op == FPD_OP_READ) begin
            rsp_rdata <= dq_in;
            rsp_valid <= 1'b1;
          end
          if (cur.op != FPD_OP_WRITE || !dq_oe) begin
            rsp_valid <= (cur.op == FPD_OP_READ);
          end
          // Both strobes rise together so the internal strobe ends cleanly
          pins.lower_byte_strobe_n <= 1'b1;
          pins.upper_byte_strobe_n <= 1'b1;
          pins.we_n <= 1'b1;
          pins.oe_n <= 1'b1;
          dq_oe     <= 1'b0;
          wait_cnt  <= CNT_BITS'(CP_CYC - 1);
          state     <= cur.keep_page ? S_IDLE : S_PRE;
        end
        S_PRE: if (wait_done && ras_min_ok) begin
          pins.ras_n <= 1'b1;
          page_open  <= 1'b0;
          wait_cnt   <= CNT_BITS'(RC_CYC - RAS_CYC);
          state      <= S_IDLE;
        end
        S_SFR_STROBE: if (wait_done) begin
          pins.ras_n <= 1'b0;
          wait_cnt   <= CNT_BITS'(RAS_CYC - 1);
          state      <= S_SFR_ROW;
        end
        S_SFR_ROW: if (wait_done) begin
          // Released before any self refresh entry time; data lanes never driven
          pins.ras_n               <= 1'b1;
          pins.lower_byte_strobe_n <= 1'b1;
          pins.upper_byte_strobe_n <= 1'b1;
          wait_cnt <= CNT_BITS'(RC_CYC - RAS_CYC);
          state    <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> rtl/fpd_pkg.sv
// Package for the fast page DRAM controller: timing counts, geometry, request carrier.
// Assumes a single 125 MHz core clock; the timing counts are derived from the ns, us and ms figures below.
package fpd_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned ROW_BITS       = 9;
  localparam int unsigned COL_BITS       = 9;
  localparam int unsigned ADDR_BITS      = 18;
  localparam int unsigned DATA_BITS      = 16;
  // Speed grade -60 figures
  localparam int unsigned T_RAC_NS       = 60;
  localparam int unsigned T_CAC_NS       = 15;
  localparam int unsigned T_AA_NS        = 30;
  localparam int unsigned T_PC_NS        = 25;
  localparam int unsigned T_RC_NS        = 110;
  localparam int unsigned T_RAS_NS       = 60;
  localparam int unsigned T_RP_NS        = 40;
  localparam int unsigned T_CP_NS        = 10;
  localparam int unsigned T_REF_MS       = 8;
  localparam int unsigned REF_ROWS       = 512;
  localparam int unsigned T_PWRUP_US     = 200;
  localparam int unsigned INIT_CYCLES    = 8;
  // Least times round up
  localparam int unsigned RAC_CYC   = (T_RAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CAC_CYC   = (T_CAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned AA_CYC    = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PC_CYC    = (T_PC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RC_CYC    = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RAS_CYC   = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RP_CYC    = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CP_CYC    = (T_CP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest time rounds down: one refresh per 8 ms / 512
  localparam int unsigned REF_INT_CYC = (T_REF_MS * 1000000) / (REF_ROWS * CLK_PERIOD_NS);
  localparam int unsigned PWRUP_CYC   = (T_PWRUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_BITS    = 16;

  typedef enum logic [1:0] {
    FPD_OP_READ,
    FPD_OP_WRITE,
    FPD_OP_RMW
  } fpd_op_t;

  typedef struct packed {
    fpd_op_t                op;
    logic [ADDR_BITS-1:0]   addr;
    logic [DATA_BITS-1:0]   wdata;
    logic [1:0]             byte_en;
    logic                   keep_page;
  } fpd_req_t;

  typedef struct packed {
    logic                   ras_n;
    logic                   lower_byte_strobe_n;
    logic                   upper_byte_strobe_n;
    logic                   we_n;
    logic                   oe_n;
    logic [ROW_BITS-1:0]    addr;
  } fpd_pins_t;
endpackage

// >>> sim/fpd_ctrl_chk.sv
// Checker for the fast page DRAM controller: timing and bus-ownership relations on its pins.
// Assumes it is bound to every fpd_ctrl instance and sees only that module's ports.
module fpd_ctrl_chk
  import fpd_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               req_ready,
  input wire logic               init_done,
  input wire fpd_pkg::fpd_pins_t pins,
  input wire logic               dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire lo_n = pins.lower_byte_strobe_n;
  wire strobe_low = !lo_n || !pins.upper_byte_strobe_n;
  sequence refresh_start;
    $fell(pins.ras_n) && strobe_low;
  endsequence
  a_ras_min: assert property ($fell(pins.ras_n) |-> !pins.ras_n [*8])
    else $error("row strobe released before least active time");
  a_precharge_min: assert property ($rose(pins.ras_n) |-> pins.ras_n [*5])
    else $error("row strobe precharge too short");
  a_refresh_float: assert property (refresh_start |-> !dq_oe [*8])
    else $error("data driven during strobe-first refresh");
  a_strobe_first: assert property ($fell(pins.ras_n) && !lo_n |-> !$past(lo_n))
    else $error("byte strobe not low before row strobe fell");
  a_page_spacing: assert property ($fell(lo_n) |=> !$fell(lo_n) [*3])
    else $error("page column cycles too close");
  a_col_stable: assert property ($fell(lo_n) && !pins.ras_n |-> $stable(pins.addr))
    else $error("column address moved at strobe fall");
  a_write_data: assert property (!pins.we_n && strobe_low && !pins.ras_n |-> dq_oe)
    else $error("write strobed without data driven");
  a_no_contention: assert property (!pins.oe_n |-> !dq_oe)
    else $error("controller drives data while outputs enabled");
  a_init_ready: assert property (!init_done |-> !req_ready)
    else $error("request accepted before initialisation");
endmodule
bind fpd_ctrl fpd_ctrl_chk u_fpd_ctrl_chk (.core_clk, .rst_n, .req_ready, .init_done, .pins,
  .dq_oe);

// >>> sim/fpd_dram_model.sv
// Behavioural model of the 256K x 16 fast page DRAM seen through its strobes.
// Assumes the pins are sampled on core_clk; released lanes show the inverse of the last value.
module fpd_dram_model
  import fpd_pkg::*;
(
  input  wire logic               core_clk,
  input  wire fpd_pkg::fpd_pins_t pins,
  input  wire logic [15:0]        dq_out,
  output logic [15:0]             dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [17:0]];
  logic [8:0]  row;
  logic [8:0]  col;
  logic [8:0]  ref_row = 9'h000;
  logic [8:0]  addr_q = 9'h000;
  int          ras_t = 0;
  int          cas_t = 0;
  int          col_t = 0;
  logic        ras_q = 1'b1;
  logic        cas_q = 1'b1;
  logic        refresh = 1'b0;
  logic [15:0] last = 16'h0000;
  int          ras_falls = 0;
  int          ref_cnt = 0;
  wire cas_n = pins.lower_byte_strobe_n & pins.upper_byte_strobe_n;
  wire [1:0] lane = {!pins.upper_byte_strobe_n, !pins.lower_byte_strobe_n};
  wire [8:0] col_now = (cas_q && !cas_n) ? pins.addr : col;
  wire rd = !pins.ras_n && !refresh && pins.we_n && !pins.oe_n;
  wire [15:0] word = mem.exists({row, col_now}) ? mem[{row, col_now}] : 16'hDEAD;
  // Counters hold elapsed cycles minus one, so data shows only once every access time is met
  wire in_time = (ras_t >= RAC_CYC - 1) && (cas_t >= CAC_CYC - 1) &&
                 (col_t >= AA_CYC - 1);
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      // Released or not yet valid lanes show the inverse of the last value
      dq_in[b*8+:8] = (rd && lane[b] && in_time) ? word[b*8+:8] : ~last[b*8+:8];
    end
  end
  always @(posedge core_clk) begin
    last <= dq_in;
    ras_q <= pins.ras_n;
    cas_q <= cas_n;
    ras_t <= pins.ras_n ? 0 : ras_t + 1;
    cas_t <= cas_n ? 0 : cas_t + 1;
    col_t <= (pins.addr != addr_q) ? 1 : col_t + 1;
    addr_q <= pins.addr;
    if (ras_q && !pins.ras_n) begin
      ras_falls++;
      refresh <= !cas_n;
      if (!cas_n) begin
        ref_row <= ref_row + 9'h001;
        ref_cnt++;
      end else begin
        row <= pins.addr;
      end
    end
    if (cas_q && !cas_n) col <= pins.addr;
    if (!pins.ras_n && !refresh && !pins.we_n && !cas_n) begin
      if (!mem.exists({row, col_now})) mem[{row, col_now}] = 16'h0000;
      for (int b = 0; b < 2; b++)
        if (lane[b]) mem[{row, col_now}][b*8+:8] = dq_out[b*8+:8];
    end
  end
endmodule

// >>> sim/tb.sv
// Self-checking bench for fpd_ctrl against the behavioural DRAM model.
// Assumes short power-up and refresh parameters so the run stays brief.
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb;
  import fpd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, rsp_valid, init_done, dq_oe;
  logic [15:0] rsp_rdata, dq_in, dq_out;
  fpd_req_t req = '0;
  fpd_pins_t pins;
  int n_fail = 0;
  int n_checks = 0;
  always #4 core_clk = ~core_clk;
  fpd_ctrl #(.PWRUP_CYCLES(20), .REF_CYCLES(1000)) u_fpd_ctrl (.core_clk, .rst_n, .req_valid,
    .req_ready, .req, .rsp_valid, .rsp_rdata, .init_done, .pins, .dq_in, .dq_out, .dq_oe);
  fpd_dram_model u_fpd_dram_model (.core_clk, .pins, .dq_out, .dq_in);
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic issue(fpd_op_t op, logic [17:0] a, logic [15:0] d, logic [1:0] be, logic kp);
    int i;
    @(negedge core_clk);
    req <= '{op: op, addr: a, wdata: d, byte_en: be, keep_page: kp};
    req_valid <= 1'b1;
    // Ready is read on the edge that takes the request, before the state moves on
    for (i = 0; i < 300; i++) begin
      @(posedge core_clk);
      if (req_ready === 1'b1) break;
    end
    if (i == 300) begin n_fail++; conclude(); end
    @(negedge core_clk);
    req_valid <= 1'b0;
  endtask
  task automatic read(logic [17:0] a, logic [1:0] be, logic kp, output logic [15:0] d);
    int i;
    issue(FPD_OP_READ, a, 16'h0000, be, kp);
    for (i = 0; i < 100 && rsp_valid !== 1'b1; i++) @(negedge core_clk);
    if (i == 100) begin n_fail++; conclude(); end
    d = rsp_rdata;
  endtask
  task automatic t_init();
    int i;
    repeat (4) @(negedge core_clk);
    `CHK("ras idle in reset", 1'b1, pins.ras_n)
    rst_n <= 1'b1;
    for (i = 0; i < 2000 && init_done !== 1'b1; i++) @(negedge core_clk);
    `CHK("init done", 1'b1, init_done)
    `CHK("init ras cycles", 1'b1, u_fpd_dram_model.ras_falls >= 8)
  endtask
  task automatic t_word_and_byte();
    logic [15:0] d;
    issue(FPD_OP_WRITE, 18'h2A5C3, 16'h1234, 2'b11, 1'b0);
    read(18'h2A5C3, 2'b11, 1'b0, d);
    `CHK("word write", 16'h1234, d)
    issue(FPD_OP_WRITE, 18'h2A5C3, 16'hFF5A, 2'b01, 1'b0);
    issue(FPD_OP_WRITE, 18'h3FFFF, 16'hA5C3, 2'b10, 1'b0);
    read(18'h2A5C3, 2'b11, 1'b0, d);
    `CHK("lower byte write", 16'h125A, d)
    read(18'h3FFFF, 2'b10, 1'b0, d);
    `CHK("upper byte read", 8'hA5, d[15:8])
  endtask
  task automatic t_page();
    logic [15:0] d;
    int f;
    f = u_fpd_dram_model.ras_falls;
    issue(FPD_OP_WRITE, 18'h00001, 16'hBEEF, 2'b11, 1'b1);
    issue(FPD_OP_WRITE, 18'h001FF, 16'hCAFE, 2'b11, 1'b1);
    read(18'h00001, 2'b11, 1'b1, d);
    `CHK("page read", 16'hBEEF, d)
    read(18'h001FF, 2'b11, 1'b0, d);
    `CHK("page last col", 16'hCAFE, d)
    `CHK("row kept open", f + 1, u_fpd_dram_model.ras_falls)
  endtask
  task automatic t_rmw();
    logic [15:0] d;
    int i;
    issue(FPD_OP_RMW, 18'h2A5C3, 16'h9876, 2'b11, 1'b0);
    for (i = 0; i < 100 && rsp_valid !== 1'b1; i++) @(negedge core_clk);
    if (i == 100) begin n_fail++; conclude(); end
    `CHK("rmw old data", 16'h125A, rsp_rdata)
    read(18'h2A5C3, 2'b11, 1'b0, d);
    `CHK("rmw new data", 16'h9876, d)
  endtask
  task automatic t_refresh();
    int r;
    r = u_fpd_dram_model.ref_cnt;
    repeat (2200) @(negedge core_clk);
    `CHK("refresh issued", 1'b1, u_fpd_dram_model.ref_cnt >= r + 2)
  endtask
  initial begin
    t_init();
    t_word_and_byte();
    t_page();
    t_rmw();
    t_refresh();
    conclude();
  end
endmodule
